// ### pkg/asc_pkg.sv
// Shared constants, types and decoding helpers of the converter control block.
package asc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register addresses on the chip register port.
  localparam logic [7:0] ADDR_CTRL_THREE  = 8'h52;
  localparam logic [7:0] ADDR_CTRL_TWO    = 8'h53;
  localparam logic [7:0] ADDR_CTRL_ONE    = 8'h54;
  localparam logic [7:0] ADDR_FIRST_HIGH  = 8'h55;
  localparam logic [7:0] ADDR_SECOND_HIGH = 8'h56;
  localparam logic [7:0] ADDR_LOW_FLAGS   = 8'h57;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int START_BIT      = 0;
  localparam int RES_BIT        = 1;
  localparam int AVG_LSB        = 2;
  localparam int INSEL_LSB      = 4;
  localparam int RATIO_LSB      = 0;
  localparam int SETTLE_BIT     = 2;
  localparam int AUX_BIAS_BIT   = 0;
  localparam int TEMP_BIAS_BIT  = 2;
  localparam int DIV_BIT        = 4;
  localparam int FIRST_LSB_POS  = 0;
  localparam int SECOND_LSB_POS = 2;
  localparam int REF_LSB        = 4;
  localparam int READY_BIT      = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and writable masks.
  localparam logic [7:0] CTRL_ONE_RST    = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST    = 8'h00;
  localparam logic [7:0] CTRL_THREE_RST  = 8'h00;
  localparam logic [7:0] CTRL_TWO_MASK   = 8'h07;
  localparam logic [7:0] CTRL_THREE_MASK = 8'h15;
  localparam logic [9:0] RESULT_RST      = 10'h000;

  ////////////////////////////////////////////////////////////////////////////
  // Input, ratiometric and reference codes.
  localparam logic [3:0] IN_BAT_DIV  = 4'h0;
  localparam logic [3:0] IN_BAT_SUB  = 4'h1;
  localparam logic [3:0] IN_AUXH_DIV = 4'h2;
  localparam logic [3:0] IN_AUXH_SUB = 4'h3;
  localparam logic [3:0] IN_TEMP     = 4'h6;
  localparam logic [3:0] IN_AUXL     = 4'h7;
  localparam logic [1:0] RATIO_NONE  = 2'h0;
  localparam logic [1:0] RATIO_TEMP  = 2'h1;
  localparam logic [1:0] RATIO_AUXL  = 2'h2;
  localparam logic [1:0] RATIO_BOTH  = 2'h3;
  localparam logic [2:0] REF_TEMP_BIAS = 3'h0;
  localparam logic [2:0] REF_AUX_BIAS  = 3'h1;
  localparam logic [2:0] REF_INT_2V0   = 3'h2;
  localparam logic [2:0] REF_SUPPLY    = 3'h3;
  localparam logic [2:0] REF_IDLE_2V0  = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Timing, derived from the 250 MHz system clock.
  localparam int CLK_MHZ         = 250;
  localparam int CLK_PERIOD_NS   = 4;
  localparam int SETTLE_SHORT_US = 10;
  localparam int SETTLE_LONG_US  = 100;
  localparam int SETTLE_SHORT_CYC = SETTLE_SHORT_US * CLK_MHZ;
  localparam int SETTLE_LONG_CYC  = SETTLE_LONG_US * CLK_MHZ;
  localparam int CONV_CLK_NS     = 2500;
  localparam int CONV_CLK_CYC    = CONV_CLK_NS / CLK_PERIOD_NS;
  localparam logic [3:0] CONV_CLKS_TEN   = 4'hb;
  localparam logic [3:0] CONV_CLKS_EIGHT = CONV_CLKS_TEN - 4'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic       wr;
    logic       rd;
  } asc_reg_req_s;

  typedef struct packed {
    logic [3:0] channel;
    logic       divOn;
    logic       subOn;
    logic       divByTwo;
    logic [2:0] refSel;
    logic       tempBias;
    logic       auxBias;
    logic       convert;
  } asc_front_s;

  // Number of samples for an averaging code.
  function automatic logic [4:0] avg_samples(input logic [1:0] code);
    // Three-bit shift amount, so code 11 gives 16 instead of wrapping to 1.
    avg_samples = (code == 2'h0) ? 5'h01
                                 : 5'(5'h01 << ({1'b0, code} + 3'h1));
  endfunction

  // Right shift that turns the sample sum into the mean.
  function automatic logic [2:0] avg_shift(input logic [1:0] code);
    avg_shift = (code == 2'h0) ? 3'h0 : 3'({1'b0, code} + 3'h1);
  endfunction

endpackage

// ### rtl/asc_averager.sv
// Sample accumulator that yields the mean over the programmed sample count.
`timescale 1ns/1ps
module asc_averager
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic       addEn,
  input  wire logic [9:0] sample,
  input  wire logic [1:0] avgCode,
  output logic      [9:0] mean
);

  logic [13:0] sum_q;
  logic [13:0] sum_d;
  logic [13:0] shifted;

  // Sixteen ten-bit samples fit in fourteen bits, so the sum never wraps.
  assign sum_d   = clear ? 14'h0000 :
                   addEn ? 14'(sum_q + {4'h0, sample}) : sum_q;
  // Truncating shift; rounding would bias the mean upward.
  assign shifted = sum_q >> asc_pkg::avg_shift(avgCode);
  assign mean    = shifted[9:0];

  // Accumulator register.
  always_ff @(posedge clk)
  begin
    if (rst)
      sum_q <= 14'h0000;
    else
      sum_q <= sum_d;
  end

  a_sum_adds: assert property (@(posedge clk) disable iff (rst)
    addEn && !clear |=> sum_q == $past(sum_q) + {4'h0, $past(sample)})
    else $error("Accumulator missed a sample.");

endmodule

// ### rtl/asc_sequence_control.sv
// Converter control registers, conversion sequencer and result registers.
//
// Behaviour
// - Writing start bit launches one sequence with the current settings.
// - Resolution bit clear gives 10-bit, set gives 8-bit results.
// - Averaging field picks 1, 4, 8 or 16 samples.
// - Input field routes battery, high aux, temperature or low aux paths.
// - Ratiometric field picks none, temperature, low aux or both.
// - Both mode: temperature result first, low aux result second.
// - Settling bit picks 10 us or 100 us before ratiometric conversion.
// - Control three bit 0 drives low aux bias switch.
// - Control three bit 2 drives temperature bias switch.
// - Divider bit clear divides by 3, set divides by 2.
// - First result high eight bits read in first status register.
// - Second result high eight bits read in second status register.
// - First result low two bits read at bits 1:0 of status three.
// - Second result low two bits read at bits 3:2 of status three.
// - Reference field reports the reference in use, resets to 111.
// - Ready flag reads 0 while idle-reset or converting, 1 when done.
// - No-power state returns every register except the core data synchroniser to its reset value.
// - Completion sets ready and pulses the ready interrupt.
// - Completion clears both bias enable bits.
// - An 8-bit conversion ends two converter clocks earlier.
`timescale 1ns/1ps
module asc_sequence_control
#(
  parameter int SETTLE_LONG_CYC = asc_pkg::SETTLE_LONG_CYC
)
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  noPowerState,
  input  wire asc_pkg::asc_reg_req_s regReq,
  output logic                 [7:0] regRdData,
  input  wire logic            [9:0] coreData,
  output asc_pkg::asc_front_s        front,
  output logic                       readyIrq
);

  typedef enum logic [1:0] {S_IDLE, S_SETTLE, S_CONV, S_STORE} asc_state_e;

  asc_state_e          state_q;
  asc_state_e          state_d;
  logic          [7:0] ctrlOne_q;
  logic          [7:0] ctrlOne_d;
  logic          [7:0] ctrlTwo_q;
  logic          [7:0] ctrlTwo_d;
  logic          [7:0] ctrlThree_q;
  logic          [7:0] ctrlThree_d;
  logic          [9:0] first_q;
  logic          [9:0] second_q;
  logic          [9:0] storeVal;
  logic          [2:0] ref_q;
  logic          [2:0] refNow;
  logic                ready_q;
  logic                readyIrq_q;
  logic          [7:0] rdData_q;
  logic          [7:0] rdValue;
  logic          [9:0] coreMeta_q;
  logic          [9:0] coreSync_q;
  logic         [14:0] settleCnt_q;
  logic         [14:0] settleTarget;
  logic          [9:0] divCnt_q;
  logic          [3:0] tickCnt_q;
  logic          [3:0] convTicks;
  logic          [4:0] sampleCnt_q;
  logic          [4:0] nSamples;
  logic                secondPass_q;
  asc_pkg::asc_front_s front_q;
  asc_pkg::asc_front_s front_d;
  logic                wipe;
  logic                busy;
  logic                wrOne;
  logic                wrTwo;
  logic                wrThree;
  logic                startCmd;
  logic                settleEnd;
  logic                divWrap;
  logic                convEnd;
  logic                lastSample;
  logic                needSecond;
  logic                donePulse;
  logic                res8;
  logic          [1:0] avgCode;
  logic          [1:0] ratio;
  logic          [3:0] activeCh;
  logic          [9:0] mean;

  ////////////////////////////////////////////////////////////////////////////
  // Register port decode and field views.

  // The no-power state resets this block like rst, except the core data synchroniser, which only rst clears.
  assign wipe     = rst || noPowerState;
  assign busy     = state_q != S_IDLE;
  assign wrOne    = regReq.wr && regReq.addr == asc_pkg::ADDR_CTRL_ONE;
  assign wrTwo    = regReq.wr && regReq.addr == asc_pkg::ADDR_CTRL_TWO;
  assign wrThree  = regReq.wr && regReq.addr == asc_pkg::ADDR_CTRL_THREE;
  // A start written during a running sequence is ignored.
  assign startCmd = wrOne && regReq.wrData[asc_pkg::START_BIT] && !busy;
  assign res8     = ctrlOne_q[asc_pkg::RES_BIT];
  assign avgCode  = ctrlOne_q[asc_pkg::AVG_LSB +: 2];
  assign ratio    = ctrlTwo_q[asc_pkg::RATIO_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // Channel and reference selection.

  // Ratiometric modes override the input field; both mode walks two pins.
  assign activeCh =
    (ratio == asc_pkg::RATIO_TEMP) ? asc_pkg::IN_TEMP :
    (ratio == asc_pkg::RATIO_AUXL) ? asc_pkg::IN_AUXL :
    (ratio == asc_pkg::RATIO_BOTH) ?
      (secondPass_q ? asc_pkg::IN_AUXL : asc_pkg::IN_TEMP) :
    ctrlOne_q[asc_pkg::INSEL_LSB +: 4];
  assign refNow =
    !busy ? ref_q :
    (ratio == asc_pkg::RATIO_NONE) ? asc_pkg::REF_INT_2V0 :
    (activeCh == asc_pkg::IN_TEMP) ? asc_pkg::REF_TEMP_BIAS :
    asc_pkg::REF_AUX_BIAS;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer timing terms.

  assign settleTarget = ctrlTwo_q[asc_pkg::SETTLE_BIT] ?
                        15'(SETTLE_LONG_CYC) : 15'(asc_pkg::SETTLE_SHORT_CYC);
  assign convTicks  = res8 ? asc_pkg::CONV_CLKS_EIGHT :
                      asc_pkg::CONV_CLKS_TEN;
  assign nSamples   = asc_pkg::avg_samples(avgCode);
  assign settleEnd  = state_q == S_SETTLE &&
                      settleCnt_q == settleTarget - 15'h1;
  assign divWrap    = divCnt_q == 10'(asc_pkg::CONV_CLK_CYC - 1);
  assign convEnd    = state_q == S_CONV && divWrap &&
                      tickCnt_q == convTicks - 4'h1;
  assign lastSample = convEnd && sampleCnt_q == nSamples - 5'h01;
  assign needSecond = ratio == asc_pkg::RATIO_BOTH && !secondPass_q;
  assign donePulse  = state_q == S_STORE && !needSecond;

  // Next state of the sequencer.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      S_IDLE:
        if (startCmd)
          state_d = (ratio == asc_pkg::RATIO_NONE) ? S_CONV : S_SETTLE;
      S_SETTLE:
        if (settleEnd)
          state_d = S_CONV;
      S_CONV:
        if (lastSample)
          state_d = S_STORE;
      S_STORE:
        state_d = needSecond ? S_SETTLE : S_IDLE;
      default:
        state_d = S_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register next values.

  // The start bit reads back 1 until the sequence finishes or control one is written while busy; a write in the
  // completion cycle still lands in the other bits.
  assign ctrlOne_d   = (wrOne ? {regReq.wrData[7:1],
                                 regReq.wrData[0] && !busy} : ctrlOne_q) &
                       (donePulse ? 8'hfe : 8'hff);
  assign ctrlTwo_d   = wrTwo ? (regReq.wrData & asc_pkg::CTRL_TWO_MASK) :
                       ctrlTwo_q;
  // Completion wins over a software write so the bias never stays on.
  assign ctrlThree_d = (wrThree ? (regReq.wrData & asc_pkg::CTRL_THREE_MASK)
                                : ctrlThree_q) &
                       (donePulse ? 8'hfa : 8'hff);
  // An 8-bit result keeps its two low bits at zero.
  assign storeVal    = res8 ? {mean[9:2], 2'h0} : mean;

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer.

  assign rdValue =
    (regReq.addr == asc_pkg::ADDR_CTRL_THREE)  ? ctrlThree_q :
    (regReq.addr == asc_pkg::ADDR_CTRL_TWO)    ? ctrlTwo_q :
    (regReq.addr == asc_pkg::ADDR_CTRL_ONE)    ? ctrlOne_q :
    (regReq.addr == asc_pkg::ADDR_FIRST_HIGH)  ? first_q[9:2] :
    (regReq.addr == asc_pkg::ADDR_SECOND_HIGH) ? second_q[9:2] :
    (regReq.addr == asc_pkg::ADDR_LOW_FLAGS)   ?
      {ready_q, ref_q, second_q[1:0], first_q[1:0]} :
    8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Front-end controls, registered so the analogue side sees clean levels.

  always_comb
  begin
    front_d          = '0;
    front_d.channel  = activeCh;
    front_d.divOn    = busy && (activeCh == asc_pkg::IN_BAT_DIV ||
                                activeCh == asc_pkg::IN_AUXH_DIV);
    front_d.subOn    = busy && (activeCh == asc_pkg::IN_BAT_SUB ||
                                activeCh == asc_pkg::IN_AUXH_SUB);
    front_d.divByTwo = ctrlThree_d[asc_pkg::DIV_BIT];
    front_d.refSel   = refNow;
    front_d.tempBias = ctrlThree_d[asc_pkg::TEMP_BIAS_BIT];
    front_d.auxBias  = ctrlThree_d[asc_pkg::AUX_BIAS_BIT];
    front_d.convert  = state_d == S_CONV;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Averager of the converted samples.

  asc_averager u_avg
  (
    .clk     (clk),
    .rst     (wipe),
    .clear   (startCmd || (state_q == S_STORE && needSecond)),
    .addEn   (convEnd),
    .sample  (coreSync_q),
    .avgCode (avgCode),
    .mean    (mean)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Core data synchroniser; the word is stable at the end of a conversion.

  always_ff @(posedge clk)
  begin
    coreMeta_q <= rst ? 10'h000 : coreData;
    coreSync_q <= rst ? 10'h000 : coreMeta_q;
  end

  // Sequencer settling, divider and tick counters.
  always_ff @(posedge clk)
  begin
    if (wipe || state_q == S_IDLE || state_q == S_STORE)
    begin
      settleCnt_q <= 15'h0000;
      divCnt_q    <= 10'h000;
      tickCnt_q   <= 4'h0;
    end
    else
    begin
      settleCnt_q <= (state_q == S_SETTLE) ? settleCnt_q + 15'h1 : 15'h0000;
      divCnt_q    <= (state_q == S_CONV && !divWrap) ? divCnt_q + 10'h1
                                                     : 10'h000;
      tickCnt_q   <= convEnd ? 4'h0 : tickCnt_q + {3'h0, divWrap};
    end
  end

  // Sample count and pass marker.
  always_ff @(posedge clk)
  begin
    state_q      <= wipe ? S_IDLE : state_d;
    sampleCnt_q  <= (wipe || startCmd || state_q == S_STORE) ? 5'h00 :
                    sampleCnt_q + {4'h0, convEnd};
    secondPass_q <= (wipe || startCmd) ? 1'b0 :
                    (state_q == S_STORE) ? 1'b1 : secondPass_q;
  end

  // Software-visible registers.
  always_ff @(posedge clk)
  begin
    if (wipe)
    begin
      ctrlOne_q   <= asc_pkg::CTRL_ONE_RST;
      ctrlTwo_q   <= asc_pkg::CTRL_TWO_RST;
      ctrlThree_q <= asc_pkg::CTRL_THREE_RST;
      ref_q       <= asc_pkg::REF_IDLE_2V0;
      ready_q     <= 1'b0;
      readyIrq_q  <= 1'b0;
      rdData_q    <= 8'h00;
      first_q     <= asc_pkg::RESULT_RST;
      second_q    <= asc_pkg::RESULT_RST;
      front_q     <= '0;
    end
    else
    begin
      ctrlOne_q   <= ctrlOne_d;
      ctrlTwo_q   <= ctrlTwo_d;
      ctrlThree_q <= ctrlThree_d;
      ref_q       <= refNow;
      ready_q     <= donePulse || (ready_q && !startCmd);
      readyIrq_q  <= donePulse;
      rdData_q    <= regReq.rd ? rdValue : 8'h00;
      first_q     <= (state_q == S_STORE && !secondPass_q) ? storeVal
                                                           : first_q;
      second_q    <= (state_q == S_STORE && secondPass_q) ? storeVal
                                                          : second_q;
      front_q     <= front_d;
    end
  end

  assign regRdData = rdData_q;
  assign front     = front_q;
  assign readyIrq  = readyIrq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_start_launch: assert property (@(posedge clk) disable iff (wipe)
    startCmd |=> busy && !ready_q ##0 ctrlOne_q[asc_pkg::START_BIT])
    else $error("Start did not launch a sequence.");
  a_res_ticks: assert property (@(posedge clk) disable iff (wipe)
    convEnd |-> tickCnt_q == (res8 ? 4'h8 : 4'ha) && divCnt_q == 10'h270)
    else $error("Conversion clock count wrong for resolution.");
  a_res_low_zero: assert property (@(posedge clk) disable iff (wipe)
    state_q == S_STORE && res8 && !secondPass_q |=> first_q[1:0] == 2'h0)
    else $error("8-bit result has low bits set.");
  a_avg_count: assert property (@(posedge clk) disable iff (wipe)
    state_q == S_STORE |-> sampleCnt_q == nSamples)
    else $error("Sample count differs from averaging setting.");
  a_div_path: assert property (@(posedge clk) disable iff (wipe)
    front_q.divOn |-> front_q.channel inside {4'h0, 4'h2})
    else $error("Divider on for a non-divider input.");
  a_ratio_ref: assert property (@(posedge clk) disable iff (wipe)
    state_q == S_CONV && ratio == asc_pkg::RATIO_TEMP
      |-> activeCh == 4'h6 && refNow == 3'h0)
    else $error("Temperature ratiometric routing wrong.");
  a_both_order: assert property (@(posedge clk) disable iff (wipe)
    state_q == S_STORE && needSecond |=> state_q == S_SETTLE ##0
      secondPass_q ##0 activeCh == 4'h7)
    else $error("Second ratiometric pass did not follow.");
  a_settle_len: assert property (@(posedge clk) disable iff (wipe)
    $rose(state_q == S_SETTLE) |-> (state_q == S_SETTLE) [*8])
    else $error("Settling ended too early.");
  a_bias_pins: assert property (@(posedge clk)
    disable iff (wipe)
    ##1 front_q.auxBias == ctrlThree_q[0] && front_q.tempBias == ctrlThree_q[2])
    else $error("Bias switch does not follow its enable.");
  a_divider_sel: assert property (@(posedge clk) disable iff (wipe)
    ##1 front_q.divByTwo == ctrlThree_q[4])
    else $error("Divider ratio does not follow its bit.");
  a_low_read: assert property (@(posedge clk) disable iff (wipe)
    regReq.rd && regReq.addr == 8'h57 |=> regRdData ==
      {$past(ready_q), $past(ref_q), $past(second_q[1:0]),
       $past(first_q[1:0])})
    else $error("Low bits register read back wrong.");
  a_high_read: assert property (@(posedge clk)
    disable iff (wipe)
    regReq.rd && regReq.addr == 8'h55 |=> regRdData == $past(first_q[9:2]))
    else $error("First result high read back wrong.");
  a_done_ready: assert property (@(posedge clk)
    disable iff (wipe)
    donePulse |=> ready_q && readyIrq_q ##1 !readyIrq_q)
    else $error("Completion did not raise ready.");
  a_busy_unready: assert property (@(posedge clk) disable iff (wipe)
    busy && state_q != S_STORE |-> !ready_q)
    else $error("Ready flag set during conversion.");
  a_bias_clear: assert property (@(posedge clk) disable iff (wipe)
    donePulse |=> ctrlThree_q[0] == 1'b0 && ctrlThree_q[2] == 1'b0)
    else $error("Bias enables not cleared at completion.");
  a_no_power_state_clear: assert property (@(posedge clk) disable iff (rst)
    noPowerState |=> ctrlOne_q == 8'h00 && !ready_q && ref_q == 3'h7 && !busy)
    else $error("No-power state left registers set.");

  c_single_done: cover property (@(posedge clk) disable iff (wipe)
    donePulse && ratio == asc_pkg::RATIO_NONE);
  c_both_done: cover property (@(posedge clk) disable iff (wipe)
    donePulse && ratio == asc_pkg::RATIO_BOTH);
  c_avg_sixteen: cover property (@(posedge clk) disable iff (wipe)
    donePulse && avgCode == 2'h3);

endmodule

// ### sim/asc_core_model.sv
// Behavioural converter core that answers the block's front-end controls.
`timescale 1ns/1ps
module asc_core_model
(
  input  wire logic                clk,
  input  wire asc_pkg::asc_front_s front,
  output logic               [9:0] coreData
);
  logic [9:0] lastQ = 10'h155;

  ////////////////////////////////////////////////////////////////////////////
  // The word follows the routed input, so swapped results stand out; off a
  // conversion the output toggles, since a stale word must never look good.
  always_ff @(posedge clk)
  begin
    if (front.convert)
      lastQ <= {front.channel, 6'h2d};
    else
      lastQ <= ~lastQ;
  end
  assign coreData = lastQ;
endmodule

// ### sim/adc_sequence_control_tb.sv
// Self-checking bench of the converter control and result registers.
`timescale 1ns/1ps
module adc_sequence_control_tb;
  logic                  clk;
  logic                  rst;
  logic                  noPowerState;
  asc_pkg::asc_reg_req_s regReq;
  logic            [7:0] regRdData;
  logic            [9:0] coreData;
  asc_pkg::asc_front_s   front;
  logic                  readyIrq;
  int                    errTotal;
  int                    cmpCount;

  // The long settle count is shortened so the run stays brief.
  asc_sequence_control #(.SETTLE_LONG_CYC(50)) dut_u
  (
    .clk(clk), .rst(rst), .noPowerState(noPowerState), .regReq(regReq),
    .regRdData(regRdData), .coreData(coreData), .front(front),
    .readyIrq(readyIrq)
  );
  asc_core_model core_u (.clk(clk), .front(front), .coreData(coreData));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, comparisons and register port cycles.
  task automatic wrap_up();
    if (errTotal == 0 && cmpCount > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      errTotal++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkCyc(input int got, input int lo, input int hi);
    cmpCount++;
    if (got < lo || got > hi)
    begin
      errTotal++;
      $display("BAD %0t duration %0d", $time, got);
    end
  endtask

  task automatic regWr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regReq.addr = a;
    regReq.wrData = d;
    regReq.wr = 1'b1;
    @(negedge clk);
    regReq.wr = 1'b0;
  endtask

  // Read data is registered, so it is looked at one edge after the strobe.
  task automatic regRd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    regReq.addr = a;
    regReq.rd = 1'b1;
    @(negedge clk);
    regReq.rd = 1'b0;
    chk(regRdData, exp);
  endtask

  // Bounded wait for the ready pulse; the pulse must last one cycle only.
  task automatic waitReady(input int base);
    int n;
    n = 0;
    while (readyIrq !== 1'b1)
    begin
      @(negedge clk);
      n++;
      if (n > base + 20)
      begin
        errTotal++;
        $display("BAD %0t no completion", $time);
        wrap_up();
      end
    end
    chkCyc(n, base - 2, base + 6);
    @(negedge clk);
    chk({7'h00, readyIrq}, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic scenReset();
    regRd(8'h52, 8'h00);
    regRd(8'h53, 8'h00);
    regRd(8'h54, 8'h00);
    regRd(8'h57, 8'h70);
    regRd(8'h50, 8'h00);
    regWr(8'h53, 8'hff);
    regWr(8'h52, 8'hff);
    regWr(8'h55, 8'hff);
    regRd(8'h53, 8'h07);
    regRd(8'h52, 8'h15);
    regRd(8'h55, 8'h00);
    chk({6'h00, front.tempBias, front.auxBias}, 8'h03);
    regWr(8'h53, 8'h00);
    regWr(8'h52, 8'h10);
  endtask

  task automatic scenSingle();
    regWr(8'h54, 8'h01);
    repeat (4) @(negedge clk);
    chk({4'h0, front.divOn, front.subOn, front.divByTwo, front.convert},
        8'h0b);
    regRd(8'h54, 8'h01);
    waitReady(6875 - 5);
    regRd(8'h55, 8'h0b);
    regRd(8'h57, 8'ha1);
    regRd(8'h54, 8'h00);
  endtask

  task automatic scenBoth();
    regWr(8'h53, 8'h07);
    regWr(8'h52, 8'h15);
    regWr(8'h54, 8'h03);
    waitReady(2 * (50 + 5625 + 1));
    regRd(8'h55, 8'h6b);
    regRd(8'h56, 8'h7b);
    regRd(8'h57, 8'h90);
    regRd(8'h52, 8'h10);
  endtask

  task automatic scenAvg();
    regWr(8'h53, 8'h00);
    regWr(8'h54, 8'h77);
    waitReady(4 * 5625);
    regRd(8'h55, 8'h7b);
    regRd(8'h57, 8'ha0);
  endtask

  task automatic scenNoPower();
    regWr(8'h53, 8'h04);
    regWr(8'h54, 8'h11);
    repeat (20) @(negedge clk);
    chk({4'h0, front.subOn, front.refSel}, 8'h0a);
    regRd(8'h57, 8'h20);
    noPowerState = 1'b1;
    repeat (2) @(negedge clk);
    noPowerState = 1'b0;
    chk({7'h00, front.convert}, 8'h00);
    regRd(8'h54, 8'h00);
    regRd(8'h53, 8'h00);
    regRd(8'h55, 8'h00);
    regRd(8'h56, 8'h00);
    regRd(8'h57, 8'h70);
    regRd(8'h52, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    errTotal = 0;
    cmpCount = 0;
    rst = 1'b1;
    noPowerState = 1'b0;
    regReq = '0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    scenReset();
    scenSingle();
    scenBoth();
    scenAvg();
    scenNoPower();
    wrap_up();
  end
endmodule
